// ---- rtl/cis_pkg.sv ----
// package for the codec init sequencer: register offsets, field positions,
// reset values and timing counts
// assumes a byte-wide register port and a 125 MHz master clock
package cis_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] CIS_OFS_GLOBAL_CONFIG  = 4'h0;  // global_config_reg
  localparam logic [3:0] CIS_OFS_CONTROL_ACK    = 4'h1;  // control_ack_reg
  localparam logic [3:0] CIS_OFS_CHAN_CMD_EN    = 4'h2;  // channel_cmd_enable_reg
  localparam logic [3:0] CIS_OFS_IRQ_STATUS     = 4'h3;  // sticky events, read only
  localparam logic [3:0] CIS_OFS_IRQ_ENABLE     = 4'h4;  // event enables
  localparam logic [3:0] CIS_OFS_IRQ_CLEAR      = 4'h5;  // write one to clear
  localparam logic [3:0] CIS_OFS_COEF_ADDR      = 4'h6;  // coefficient ram address
  localparam logic [3:0] CIS_OFS_COEF_DATA      = 4'h7;  // coefficient ram data
  // global configuration fields
  localparam int         CIS_BIT_SW_RESET       = 7;     // software reset request
  localparam int         CIS_POS_CHAN_ACTIVE    = 0;     // channel active field low bit
  localparam int         CIS_POS_CHAN_ACT_HI    = 3;     // active field is bits 3..0 after shift
  localparam logic [7:0] CIS_RST_GLOBAL_CONFIG  = 8'hbf; // reset value, sw reset set
  // control acknowledge fields
  localparam int         CIS_BIT_INIT_DONE      = 1;     // init program finished
  localparam int         CIS_BIT_ACK_READY      = 0;     // command port ready
  // channel command enable fields
  localparam int         CIS_BIT_RAM_PWR_STBY   = 7;     // ram_power_in_standby_bit
  localparam logic [7:0] CIS_RST_CHAN_CMD_EN    = 8'h80;
  // interrupt event bits
  localparam int         CIS_EVT_INIT_DONE      = 0;
  localparam int         CIS_EVT_UNINIT         = 1;
  localparam int         CIS_EVT_NUM            = 2;
  // timing: one frame sync period is 125 us
  localparam int         CIS_FRAME_NS           = 125000;
  localparam int         CIS_CLK_NS             = 8;
  localparam int         CIS_FRAME_CYC          = CIS_FRAME_NS / CIS_CLK_NS;
  localparam int         CIS_INIT_FRAMES        = 2;     // frames from activation to done
  // init engine states
  typedef enum logic [1:0]
  {
    CIS_ST_UNINIT = 2'b00,  // reset seen, init program owed
    CIS_ST_WAIT   = 2'b01,  // sw reset released, no active channel
    CIS_ST_RUN    = 2'b10,  // counting frames with a channel active
    CIS_ST_DONE   = 2'b11   // init done, ram open with a channel up or ram kept powered
  } cis_state_t;
  // register port request
  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cis_req_t;
endpackage

// ---- rtl/cis_frame_counter.sv ----
// counts frame sync pulses while enabled and flags a target count
// assumes frame_sync is a one-cycle pulse synchronous to clk
`timescale 1ns/100ps
module cis_frame_counter
  import cis_pkg::*;
#(
  parameter int TARGET = CIS_INIT_FRAMES
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic frame_sync,
  output logic      reached
);
  localparam int CW = $clog2(TARGET + 1);
  // refused at elaboration, a zero target would raise reached as soon as run rises
  if (TARGET < 1)
    $error("frame target must be at least one");
  logic [CW-1:0] count;  // frames seen since run rose
  // counter restarts whenever run drops, so a channel going idle resets the wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (!run)
      count <= '0;
    else if (frame_sync && !reached)
      count <= count + CW'(1);
  end
  assign reached = run && (count == CW'(TARGET));
endmodule

// ---- rtl/cis_coef_ram.sv ----
// coefficient ram, registered read data
// assumes the caller gates access before init is done
`timescale 1ns/100ps
module cis_coef_ram
#(
  parameter int AW = 6,
  parameter int DW = 8
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  // refused at elaboration
  if (AW < 1 || DW < 1)
    $error("ram geometry must be positive");
  logic [DW-1:0] mem [0:(1<<AW)-1];  // storage, no reset
  // single port, write first is not needed by the caller
  always_ff @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule

// ---- rtl/cis_init_sequencer.sv ----
// codec init sequencer: reset tracking, init program timing, ram gating
// assumes the host keeps clk and frame_sync running and uses the register port
//
// Notes on behaviour
// - four reset causes (rst_n, por_n, mode_select_pin, sw reset) force the uninitialized state
// - init only runs with a channel active
// - two frames after activation, done flag, ram opens
// - global config reads bf after reset
// - download with channel active or ram kept powered
`timescale 1ns/100ps
module cis_init_sequencer
  import cis_pkg::*;
#(
  parameter int RAM_AW = 6
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       por_n,
  input  wire logic       mode_select_pin,
  input  wire logic       frame_sync,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            init_done,
  output logic            coef_access_err,
  output logic            irq
);
  // refused at elaboration, the pointer register is one byte
  if (RAM_AW < 1 || RAM_AW > 8)
    $error("ram address must fit the 8-bit address register");

  // reset release through two flops; rst_n, por_n and mode_select_pin all assert it
  logic       rst_async_n;         // combined asynchronous reset
  logic [1:0] rst_sync;            // release shift stage
  logic       srst_n;              // released reset used by the design
  assign rst_async_n = rst_n && por_n && mode_select_pin;
  always_ff @(posedge clk or negedge rst_async_n)
  begin
    if (!rst_async_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign srst_n = rst_sync[1];

  cis_req_t req;                   // bundled register request
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // registers
  logic [7:0]  global_config_reg;  // sw reset and channel activity
  logic [7:0]  channel_cmd_enable_reg;  // channel select and ram power
  logic [7:0]  coef_addr;          // ram pointer
  logic [CIS_EVT_NUM-1:0] irq_status;
  logic [CIS_EVT_NUM-1:0] irq_enable;
  cis_state_t  state;
  cis_state_t  next_state;

  // write decode
  logic wr_cfg, wr_cmd, wr_ien, wr_clr, wr_cadr, wr_cdat, rd_cdat;
  assign wr_cfg  = req.wr && (req.addr == CIS_OFS_GLOBAL_CONFIG);
  assign wr_cmd  = req.wr && (req.addr == CIS_OFS_CHAN_CMD_EN);
  assign wr_ien  = req.wr && (req.addr == CIS_OFS_IRQ_ENABLE);
  assign wr_clr  = req.wr && (req.addr == CIS_OFS_IRQ_CLEAR);
  assign wr_cadr = req.wr && (req.addr == CIS_OFS_COEF_ADDR);
  assign wr_cdat = req.wr && (req.addr == CIS_OFS_COEF_DATA);
  assign rd_cdat = req.rd && (req.addr == CIS_OFS_COEF_DATA);

  // channel activity: active field is the low four bits, 1 means powered down
  logic sw_reset;                  // software reset held
  logic any_active;                // at least one channel up
  logic all_down;                  // every channel powered down
  assign sw_reset   = global_config_reg[CIS_BIT_SW_RESET];
  assign any_active = !sw_reset &&
                      !(&global_config_reg[CIS_POS_CHAN_ACT_HI:CIS_POS_CHAN_ACTIVE]);
  assign all_down   = !any_active;

  // global config; writing bit 7 puts the device back to uninit
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      global_config_reg <= CIS_RST_GLOBAL_CONFIG;
    else if (wr_cfg)
      global_config_reg <= req.wdata;
  end

  // channel select and ram power bit
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      channel_cmd_enable_reg <= CIS_RST_CHAN_CMD_EN;
    else if (wr_cmd)
      channel_cmd_enable_reg <= req.wdata;
  end

  // frame counting while the init program runs
  logic frames_done;               // two frames elapsed with a channel up
  cis_frame_counter #(
    .TARGET (CIS_INIT_FRAMES)
  ) u_frames (
    .clk        (clk),
    .rst_n      (srst_n),
    .run        (state == CIS_ST_RUN),
    .frame_sync (frame_sync),
    .reached    (frames_done)
  );

  // init engine: sw reset always wins and returns to uninit
  always_comb
  begin
    next_state = state;
    unique case (state)
      CIS_ST_UNINIT:
        if (!sw_reset)
          next_state = CIS_ST_WAIT;
      CIS_ST_WAIT:
        if (any_active)
          next_state = CIS_ST_RUN;
      CIS_ST_RUN:
        if (!any_active)
          next_state = CIS_ST_WAIT;
        else if (frames_done)
          next_state = CIS_ST_DONE;
      CIS_ST_DONE:
        next_state = CIS_ST_DONE;
    endcase
    if (sw_reset)
      next_state = CIS_ST_UNINIT;
  end

  // state register
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      state <= CIS_ST_UNINIT;
    else
      state <= next_state;
  end

  // ram access allowed once done, with a channel up or ram kept powered
  logic ram_open;
  assign ram_open = (state == CIS_ST_DONE) &&
                    (any_active || (all_down && !channel_cmd_enable_reg[CIS_BIT_RAM_PWR_STBY]));

  // coefficient pointer auto-increments on each data access while the ram is open
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      coef_addr <= 8'h00;
    else if (wr_cadr)
      coef_addr <= req.wdata;
    else if ((wr_cdat || rd_cdat) && ram_open)
      coef_addr <= coef_addr + 8'h01;
  end

  logic [7:0] ram_rdata;
  cis_coef_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_ram (
    .clk   (clk),
    .we    (wr_cdat && ram_open),
    .addr  (coef_addr[RAM_AW-1:0]),
    .wdata (req.wdata),
    .rdata (ram_rdata)
  );

  // events; set beats clear in the same cycle
  logic [CIS_EVT_NUM-1:0] evt;
  assign evt[CIS_EVT_INIT_DONE] = (state == CIS_ST_RUN) && (next_state == CIS_ST_DONE);
  assign evt[CIS_EVT_UNINIT]    = (state != CIS_ST_UNINIT) && (next_state == CIS_ST_UNINIT);
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      irq_status <= '0;
    else
      irq_status <= evt | (irq_status & ~(wr_clr ? req.wdata[CIS_EVT_NUM-1:0] : '0));
  end

  // interrupt enables
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      irq_enable <= '0;
    else if (wr_ien)
      irq_enable <= req.wdata[CIS_EVT_NUM-1:0];
  end

  // registered outputs
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      irq             <= 1'b0;
      init_done       <= 1'b0;
      coef_access_err <= 1'b0;
    end
    else
    begin
      irq             <= |(irq_status & irq_enable);
      init_done       <= (next_state == CIS_ST_DONE);
      coef_access_err <= (wr_cdat || rd_cdat) && !ram_open;
    end
  end

  // read mux; ram data arrive one cycle after the strobe, as all reads do
  logic       rd_q;                // read strobe delayed
  logic       rd_ram_q;            // read was of ram data
  logic [7:0] rd_reg_q;            // captured register value
  logic [7:0] rd_val;
  always_comb
  begin
    rd_val = 8'h00;
    unique case (req.addr)
      CIS_OFS_GLOBAL_CONFIG: rd_val = global_config_reg;
      CIS_OFS_CONTROL_ACK:
      begin
        rd_val[CIS_BIT_INIT_DONE] = (state == CIS_ST_DONE);
        rd_val[CIS_BIT_ACK_READY] = 1'b1;                    // port always ready
      end
      CIS_OFS_CHAN_CMD_EN:   rd_val = channel_cmd_enable_reg;
      CIS_OFS_IRQ_STATUS:    rd_val = {6'h00, irq_status};
      CIS_OFS_IRQ_ENABLE:    rd_val = {6'h00, irq_enable};
      CIS_OFS_COEF_ADDR:     rd_val = coef_addr;
      default:               rd_val = 8'h00;  // unmapped and write-only
    endcase
  end
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      rd_q     <= 1'b0;
      rd_ram_q <= 1'b0;
      rd_reg_q <= 8'h00;
    end
    else
    begin
      rd_q     <= req.rd;
      rd_ram_q <= rd_cdat && ram_open;
      rd_reg_q <= rd_val;
    end
  end
  // rdata is a pure mux of two flops; read ram output sits in a flop already
  assign rdata = !rd_q ? 8'h00 : (rd_ram_q ? ram_rdata : rd_reg_q);

  // assertions
  // helper: frame pulses seen since the engine entered run, saturating
  logic [3:0] ast_frames;
  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
      ast_frames <= 4'h0;
    else if (state != CIS_ST_RUN)
      ast_frames <= 4'h0;  // leaving run restarts the count, as the engine does
    else if (frame_sync && (ast_frames != 4'hf))
      ast_frames <= ast_frames + 4'h1;
  end

  // steps of the init program and of a refused ram access
  sequence s_in_run;
    state == CIS_ST_RUN;
  endsequence
  sequence s_in_done;
    state == CIS_ST_DONE;
  endsequence
  sequence s_data_refused;
    (wr_cdat || rd_cdat) && !ram_open;
  endsequence

  AST_RESET_CONFIG: assert property (@(posedge clk)
    $rose(srst_n) |-> (global_config_reg == CIS_RST_GLOBAL_CONFIG))
    else $error("config not bf after reset");
  AST_SW_RESET_UNINIT: assert property (@(posedge clk) disable iff (!srst_n)
    sw_reset |=> (state == CIS_ST_UNINIT))
    else $error("sw reset did not force uninit");
  AST_NO_DONE_IDLE: assert property (@(posedge clk) disable iff (!srst_n)
    (state == CIS_ST_RUN && !any_active) |=> (state != CIS_ST_DONE))
    else $error("init finished with no active channel");
  AST_DONE_NEEDS_FRAMES: assert property (@(posedge clk) disable iff (!srst_n)
    s_in_run ##1 s_in_done |-> (ast_frames == 4'(CIS_INIT_FRAMES)))
    else $error("done without two frames in run");
  AST_DONE_FLAG: assert property (@(posedge clk) disable iff (!srst_n)
    (state == CIS_ST_DONE) |-> init_done)
    else $error("done flag not shown");
  AST_RAM_GATED: assert property (@(posedge clk) disable iff (!srst_n)
    (wr_cdat && state != CIS_ST_DONE) |=> coef_access_err)
    else $error("ram write allowed before init");
  AST_OPEN_AFTER_DONE: assert property (@(posedge clk) disable iff (!srst_n)
    (wr_cdat && state == CIS_ST_DONE && any_active) |=> !coef_access_err)
    else $error("ram write refused after init");
  AST_REFUSED_NO_MOVE: assert property (@(posedge clk) disable iff (!srst_n)
    (s_data_refused ##0 !wr_cadr) |=> $stable(coef_addr))
    else $error("pointer moved on refused access");
  AST_REFUSED_READ_ZERO: assert property (@(posedge clk) disable iff (!srst_n)
    (s_data_refused ##0 rd_cdat) |=> (rdata == 8'h00))
    else $error("refused ram read returned data");
  AST_PDR_GATE: assert property (@(posedge clk) disable iff (!srst_n)
    (wr_cdat && all_down && channel_cmd_enable_reg[CIS_BIT_RAM_PWR_STBY]) |=> coef_access_err)
    else $error("ram write with ram powered off");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!srst_n)
    $past(|(irq_status & irq_enable)) == irq)
    else $error("irq level wrong");
endmodule

// ---- test/cis_host_model.sv ----
// host side model: keeps frame sync running beside the sequencer
// assumes one clk shared with the bench; frame period shortened for sim
`timescale 1ns/100ps
module cis_host_model
#(
  parameter int PERIOD = 40  // cycles per frame, far above 8 kHz to keep runs short
)
(
  input  wire logic clk,
  output logic      frame_sync
);
  int cnt = 0;  // cycles into the frame

  // one-cycle pulse each frame, never paused while programming
  always @(posedge clk)
  begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    frame_sync <= (cnt == PERIOD - 1);
  end
endmodule

// ---- test/test_codec_init_sequencer.sv ----
// self-checking bench for the codec init sequencer
// assumes the host model makes frame sync; bench owns the register port
`timescale 1ns/100ps
module test_codec_init_sequencer
  import cis_pkg::*;
;
  localparam int FRAME = 40;     // shortened frame period
  localparam int LIMIT = 20000;  // hang ceiling, tests need about 1700 cycles

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;           // held low at start
  logic       por_n = 1'b1;
  logic       mode_select_pin = 1'b1;
  logic       frame_sync;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       init_done;
  logic       coef_access_err;
  logic       irq;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         errs = 0;               // refusal pulses seen
  logic       rd_seen = 1'b0;         // read taken last edge
  logic [7:0] exp_q[$];               // expected read data, oldest first
  string      what_q[$];              // names of pending reads
  logic [7:0] coef[4];                // random ram contents

  always #4 clk = ~clk;

  cis_init_sequencer uut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .mode_select_pin(mode_select_pin),
    .frame_sync(frame_sync), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .init_done(init_done), .coef_access_err(coef_access_err), .irq(irq));

  cis_host_model #(.PERIOD(FRAME)) host (.clk(clk), .frame_sync(frame_sync));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // note the expectation first, the watcher pops it a cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    exp_q.push_back(exp);
    what_q.push_back(what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic wait_frames(input int n);
    repeat (n)
    begin
      @(posedge clk);
      while (frame_sync !== 1'b1)
        @(posedge clk);
    end
  endtask

  // release sw reset, prove idle without channels, activate, count frames
  task automatic bring_up();
    int pulses;
    pulses = 0;
    wait_frames(5);
    wr_reg(CIS_OFS_GLOBAL_CONFIG, 8'h3f);
    wait_frames(3);
    check("done without channel", {7'h0, init_done}, 8'h00);
    // channels drop after one frame of the count: the wait must restart
    wr_reg(CIS_OFS_GLOBAL_CONFIG, 8'h30);
    wait_frames(1);
    wr_reg(CIS_OFS_GLOBAL_CONFIG, 8'h3f);
    wait_frames(2);
    check("done after channel drop", {7'h0, init_done}, 8'h00);
    wr_reg(CIS_OFS_GLOBAL_CONFIG, 8'h30);
    repeat (4 * FRAME)
    begin
      @(posedge clk);
      if (init_done === 1'b1)
        break;
      if (frame_sync === 1'b1)
        pulses++;
    end
    check("frames to done", 8'(pulses), 8'h02);
  endtask

  // watcher: read data, refusal pulses, hang ceiling
  always @(posedge clk)
  begin
    cycles++;
    if (coef_access_err === 1'b1)
      errs++;
    if (rd_seen)
      check(what_q.pop_front(), rdata, exp_q.pop_front());
    rd_seen <= rd;
    if (cycles == LIMIT)
    begin
      miscompares++;
      give_verdict();
    end
  end

  initial
  begin
    void'($urandom(26034));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset state, ram locked before init
    rd_chk(CIS_OFS_GLOBAL_CONFIG, 8'hbf, "config after reset");
    rd_chk(CIS_OFS_CONTROL_ACK, 8'h01, "ack before init");
    wr_reg(CIS_OFS_COEF_DATA, 8'h5a);
    rd_chk(CIS_OFS_COEF_DATA, 8'h00, "ram before init");
    rd_chk(4'h8, 8'h00, "unmapped read");
    check("refusals before init", 8'(errs), 8'h02);
    $display("test reset_state done");
    // init sequence, then irq raise, mask and clear
    wr_reg(CIS_OFS_IRQ_ENABLE, 8'h01);
    bring_up();
    repeat (2) @(posedge clk);
    check("irq on done", {7'h0, irq}, 8'h01);
    rd_chk(CIS_OFS_CONTROL_ACK, 8'h03, "ack after init");
    rd_chk(CIS_OFS_IRQ_STATUS, 8'h01, "status after init");
    wr_reg(CIS_OFS_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge clk);
    check("irq masked", {7'h0, irq}, 8'h00);
    wr_reg(CIS_OFS_IRQ_ENABLE, 8'h01);
    wr_reg(CIS_OFS_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge clk);
    check("irq cleared", {7'h0, irq}, 8'h00);
    rd_chk(CIS_OFS_IRQ_STATUS, 8'h00, "status cleared");
    $display("test init_irq done");
    // coefficient download with a channel selected
    wr_reg(CIS_OFS_CHAN_CMD_EN, 8'h01);
    wr_reg(CIS_OFS_COEF_ADDR, 8'h00);
    foreach (coef[i])
    begin
      coef[i] = 8'($urandom);
      wr_reg(CIS_OFS_COEF_DATA, coef[i]);
    end
    wr_reg(CIS_OFS_COEF_ADDR, 8'h00);
    foreach (coef[i])
      rd_chk(CIS_OFS_COEF_DATA, coef[i], "ram readback");
    // all channels down: standby bit set refuses, cleared allows
    wr_reg(CIS_OFS_GLOBAL_CONFIG, 8'h3f);
    wr_reg(CIS_OFS_CHAN_CMD_EN, 8'h81);
    wr_reg(CIS_OFS_COEF_DATA, 8'h77);
    wr_reg(CIS_OFS_CHAN_CMD_EN, 8'h01);
    wr_reg(CIS_OFS_COEF_ADDR, 8'h00);
    rd_chk(CIS_OFS_COEF_DATA, coef[0], "ram kept powered");
    check("refusals total", 8'(errs), 8'h03);
    $display("test coef_download done");
    // sw reset, mode pin low, power-on reset in turn
    for (int c = 0; c < 3; c++)
    begin
      if (c > 0)
        bring_up();
      wr_reg(CIS_OFS_IRQ_CLEAR, 8'h03);
      if (c == 0)
        wr_reg(CIS_OFS_GLOBAL_CONFIG, 8'hbf);
      else
      begin
        @(posedge clk);
        mode_select_pin <= (c != 1);
        por_n <= (c != 2);
        repeat (2) @(posedge clk);
        mode_select_pin <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
      end
      repeat (2) @(posedge clk);
      check("done after reset", {7'h0, init_done}, 8'h00);
      rd_chk(CIS_OFS_GLOBAL_CONFIG, 8'hbf, "config after reset");
      rd_chk(CIS_OFS_IRQ_STATUS, (c == 0) ? 8'h02 : 8'h00, "uninit event");
      rd_chk(CIS_OFS_CONTROL_ACK, 8'h01, "ack after reset");
    end
    $display("test reset_causes done");
    give_verdict();
  end
endmodule
